// >>> lnb_output_select_i2c_slave_tb.sv
// self-checking bench for the dish supply selector and its bus slave
module lnb_output_select_i2c_slave_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     core_clk_i = 1'b0;
    logic                     rstn_i     = 1'b0;
    logic                     en_pin     = 1'b0;
    logic                     vsel_pin   = 1'b0;
    logic [1:0]               strap      = 2'h0;
    wire                      scl;
    wire                      m_sda;
    wire                      sda_o;
    wire                      sda_oen_o;
    lnbsl_pkg::lnbsl_supply_t dso;
    int                       err_total  = 0;
    int                       n_checks   = 0;
    // oen low pulls the wire low; pull-up otherwise
    wire                      sda_line   = m_sda & sda_oen_o;

    always #10 core_clk_i = ~core_clk_i;

    lnbsl_master_model lnbsl_master_model_inst (.scl_o(scl), .sda_drv_o(m_sda), .sda_i(sda_line));

    lnbsl_top lnbsl_top_inst (
        .core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oen_o(sda_oen_o), .enable_pin_i(en_pin), .voltage_select_pin_i(vsel_pin),
        .addr_strap_i(strap), .dish_supply_output_o(dso));

    // ****************************************************************
    // shared helpers
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #2;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // whole frame is always sent; refused bytes just show up as missing acks
    task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, input logic [2:0] exp);
        logic [2:0] ack;
        step(1);
        lnbsl_master_model_inst.start();
        lnbsl_master_model_inst.send_byte({a, 1'b0}, ack[2]);
        lnbsl_master_model_inst.send_byte(r, ack[1]);
        lnbsl_master_model_inst.send_byte(d, ack[0]);
        lnbsl_master_model_inst.stop();
        check({5'h0, ack}, {5'h0, exp}, "ack pattern");
        check({7'h0, sda_o}, 8'h00, "drive level");
        step(6);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_pins();
        logic [3:0] c;
        en_pin = 1'b1;
        for (int i = 0; i < 4; i++) begin
            vsel_pin = i[0];
            lnbsl_master_model_inst.set_scl(i[1]);
            step(6);
            c = (i[0] ? 4'hc : 4'h4) + (i[1] ? 4'h2 : 4'h0);
            check({3'h0, dso}, {4'h1, c}, "pin level");
        end
        lnbsl_master_model_inst.set_scl(1'b1);
        en_pin = 1'b0;
        step(6);
        check({7'h0, dso.on}, 8'h00, "pin off");
    endtask

    task automatic t_refuse();
        wr(lnbsl_pkg::ADDR_GND, 8'h01, 8'h88, 3'b000);
        en_pin = 1'b1;
        step(4);
        wr(7'h12, 8'h01, 8'h88, 3'b000);
        wr(7'h00, 8'h01, 8'h88, 3'b000);
        wr(lnbsl_pkg::ADDR_GND, 8'h02, 8'h88, 3'b100);
        check({3'h0, dso}, {4'h1, 4'he}, "still pin mode");
    endtask

    task automatic t_reg();
        logic [6:0] at[4] = '{lnbsl_pkg::ADDR_GND, lnbsl_pkg::ADDR_FLOAT,
                              lnbsl_pkg::ADDR_VCC, lnbsl_pkg::ADDR_DIVIDER};
        // level writes land while the source bit is still 0
        for (int s = 0; s < 4; s++) begin
            strap = s[1:0];
            step(6);
            wr(at[s], 8'h00, {3'h0, 4'h3 + s[3:0], 1'b0}, 3'b111);
        end
        wr(at[3], 8'h01, 8'h88, 3'b111);
        check({3'h0, dso}, {4'h1, 4'h6}, "register level");
        wr(at[3], 8'h00, 8'h1e, 3'b111);
        check({3'h0, dso}, {4'h1, 4'hf}, "top code");
        en_pin   = 1'b0;
        vsel_pin = 1'b0;
        lnbsl_master_model_inst.set_scl(1'b0);
        step(8);
        check({3'h0, dso}, {4'h1, 4'hf}, "pins ignored");
        lnbsl_master_model_inst.set_scl(1'b1);
        en_pin = 1'b1;
        step(4);
        wr(at[3], 8'h01, 8'h80, 3'b111);
        check({7'h0, dso.on}, 8'h00, "register off");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        #400us;
        err_total++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge core_clk_i);
        #2 rstn_i = 1'b1;
        step(5);
        t_pins();
        t_refuse();
        t_reg();
        summarize();
    end
endmodule

// >>> lnbsl_master_model.sv
// serial bus master model driving the clock directly and data as an open-drain host
module lnbsl_master_model (
    output logic      scl_o,
    output logic      sda_drv_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // bus conditions; 160 ns bit period, clock stands still between frames
    // ****************************************************************
    initial begin
        scl_o     = 1'b1;
        sda_drv_o = 1'b1;
    end

    task automatic set_scl(input logic lvl);
        scl_o = lvl;
    endtask

    // the master frames every transfer with start and stop
    task automatic start();
        sda_drv_o = 1'b1;
        scl_o     = 1'b1;
        #80 sda_drv_o = 1'b0;
        #80 scl_o = 1'b0;
        #40;
    endtask

    task automatic stop();
        sda_drv_o = 1'b0;
        #40 scl_o = 1'b1;
        #80 sda_drv_o = 1'b1;
        #80;
    endtask

    // msb first, then releases data and samples ack mid clock high
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv_o = b[i];
            #40 scl_o = 1'b1;
            #80 scl_o = 1'b0;
            #40;
        end
        sda_drv_o = 1'b1;
        #40 scl_o = 1'b1;
        #40 ack = ~sda_i;
        #40 scl_o = 1'b0;
        #40;
    endtask
endmodule

// >>> lnbsl_sync.sv
// package for the dish supply selector and its two-flop input synchroniser
// ****************************************************************
// shared constants and types
// ****************************************************************
package lnbsl_pkg;

    // register indices and reset values
    localparam logic [7:0] REG_LEVEL     = 8'h00;
    localparam logic [7:0] REG_CONTROL   = 8'h01;
    localparam int         NUM_REGS      = 2;
    localparam logic [7:0] LEVEL_RST     = 8'h08;
    localparam logic [7:0] CONTROL_RST   = 8'h09;

    // field positions
    localparam int         SRC_BIT       = 7;
    localparam int         REG_EN_BIT    = 3;
    localparam int         CODE_LSB      = 1;
    localparam int         CODE_MSB      = 4;

    // output level codes: 11 V plus 0.6 V per step
    localparam logic [3:0] CODE_13V4     = 4'h4;
    localparam logic [3:0] CODE_14V6     = 4'h6;
    localparam logic [3:0] CODE_18V2     = 4'hc;
    localparam logic [3:0] CODE_19V4     = 4'he;
    localparam logic [3:0] CODE_OFF      = 4'h0;

    // address pin levels and the matching 7-bit slave addresses
    localparam logic [1:0] STRAP_GND     = 2'h0;
    localparam logic [1:0] STRAP_FLOAT   = 2'h1;
    localparam logic [1:0] STRAP_VCC     = 2'h2;
    localparam logic [1:0] STRAP_DIVIDER = 2'h3;
    localparam logic [6:0] ADDR_GND      = 7'h10;
    localparam logic [6:0] ADDR_FLOAT    = 7'h09;
    localparam logic [6:0] ADDR_VCC      = 7'h08;
    localparam logic [6:0] ADDR_DIVIDER  = 7'h11;

    // byte positions within a write frame
    localparam logic [1:0] BYTE_ADDR     = 2'h0;
    localparam logic [1:0] BYTE_REG      = 2'h1;
    localparam logic [1:0] BYTE_DATA     = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef struct packed {
        logic       on;
        logic [3:0] level_code;
    } lnbsl_supply_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RECV = 4'b0010,
        ST_ACK  = 4'b0100,
        ST_SKIP = 4'b1000
    } lnbsl_state_t;

endpackage

// ****************************************************************
// two-flop synchroniser, one stage pair per bit
// ****************************************************************
module lnbsl_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         rstn_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_i[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign sync_o = sync_q;
endmodule

// >>> lnbsl_top.sv
// dish supply level selector with a write-only serial bus slave

module lnbsl_top #(
    parameter int NUM_REGS = lnbsl_pkg::NUM_REGS
) (
    input  wire logic                    core_clk_i,
    input  wire logic                    rstn_i,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oen_o,
    input  wire logic                    enable_pin_i,
    input  wire logic                    voltage_select_pin_i,
    input  wire logic [1:0]              addr_strap_i,
    output lnbsl_pkg::lnbsl_supply_t     dish_supply_output_o
);
    // ****************************************************************
    // input synchronisation
    // ****************************************************************
    logic [5:0] raw_in;
    logic [5:0] syn_in;
    logic       scl_s;
    logic       sda_s;
    logic       en_s;
    logic       vsel_s;
    logic [1:0] strap_s;

    assign raw_in = {addr_strap_i, voltage_select_pin_i, enable_pin_i, sda_i, scl_i};

    lnbsl_sync #(
        .W          (6)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    (raw_in),
        .sync_o     (syn_in)
    );

    assign scl_s   = syn_in[0];
    assign sda_s   = syn_in[1];
    assign en_s    = syn_in[2];
    assign vsel_s  = syn_in[3];
    assign strap_s = syn_in[5:4];

    // ****************************************************************
    // bus condition detection
    // ****************************************************************
    logic scl_p_q;
    logic sda_p_q;
    wire  scl_rise  = scl_s & ~scl_p_q;
    wire  scl_fall  = ~scl_s & scl_p_q;
    wire  start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire  stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // own address from the strap level
    logic [6:0] own_addr;
    assign own_addr = (strap_s == lnbsl_pkg::STRAP_VCC)   ? lnbsl_pkg::ADDR_VCC   :
                      (strap_s == lnbsl_pkg::STRAP_FLOAT) ? lnbsl_pkg::ADDR_FLOAT :
                      (strap_s == lnbsl_pkg::STRAP_GND)   ? lnbsl_pkg::ADDR_GND   :
                                                            lnbsl_pkg::ADDR_DIVIDER;

    // ****************************************************************
    // byte receiver and acknowledge
    // ****************************************************************
    lnbsl_pkg::lnbsl_state_t state_q;
    lnbsl_pkg::lnbsl_state_t state_d;
    logic [3:0]              bit_cnt_q;
    logic [1:0]              byte_cnt_q;
    logic [7:0]              shift_q;
    logic [7:0]              reg_idx_q;
    logic [NUM_REGS-1:0][7:0] regs_q;

    wire byte_done = (state_q == lnbsl_pkg::ST_RECV) && scl_fall && (bit_cnt_q == lnbsl_pkg::BITS_PER_BYTE);
    // write bit must be 0; general call (address 0) never equals a strap address
    wire addr_hit  = (shift_q[7:1] == own_addr) && !shift_q[0] && en_s;
    wire reg_hit   = shift_q < 8'(NUM_REGS);
    wire ack_ok    = (byte_cnt_q == lnbsl_pkg::BYTE_ADDR) ? addr_hit :
                     (byte_cnt_q == lnbsl_pkg::BYTE_REG)  ? reg_hit  :
                     (byte_cnt_q == lnbsl_pkg::BYTE_DATA) ? en_s     : 1'b0;
    wire commit    = byte_done && ack_ok && (byte_cnt_q == lnbsl_pkg::BYTE_DATA);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            lnbsl_pkg::ST_IDLE: begin
                state_d = lnbsl_pkg::ST_IDLE;
            end
            lnbsl_pkg::ST_RECV: begin
                if (byte_done) begin
                    state_d = ack_ok ? lnbsl_pkg::ST_ACK : lnbsl_pkg::ST_SKIP;
                end
            end
            lnbsl_pkg::ST_ACK: begin
                if (scl_fall) begin
                    // single update per frame; further bytes go unanswered
                    state_d = (byte_cnt_q == lnbsl_pkg::BYTE_DATA) ? lnbsl_pkg::ST_SKIP : lnbsl_pkg::ST_RECV;
                end
            end
            lnbsl_pkg::ST_SKIP: begin
                state_d = lnbsl_pkg::ST_SKIP;
            end
            default: begin
                state_d = lnbsl_pkg::ST_IDLE;
            end
        endcase
        if (start_det) begin
            state_d = lnbsl_pkg::ST_RECV;
        end else if (stop_det) begin
            state_d = lnbsl_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= lnbsl_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_cnt_q  <= 4'h0;
            byte_cnt_q <= lnbsl_pkg::BYTE_ADDR;
            shift_q    <= 8'h00;
        end else if (start_det) begin
            bit_cnt_q  <= 4'h0;
            byte_cnt_q <= lnbsl_pkg::BYTE_ADDR;
        end else if (state_q == lnbsl_pkg::ST_RECV && scl_rise) begin
            bit_cnt_q  <= bit_cnt_q + 4'h1;
            shift_q    <= {shift_q[6:0], sda_s};  // msb first
        end else if (state_q == lnbsl_pkg::ST_ACK && scl_fall) begin
            bit_cnt_q  <= 4'h0;
            byte_cnt_q <= byte_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_idx_q <= 8'h00;
        end else if (byte_done && byte_cnt_q == lnbsl_pkg::BYTE_REG) begin
            reg_idx_q <= shift_q;
        end
    end

    // registers are written whatever the control-source bit says
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
        always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
                regs_q[r] <= (r == 0) ? lnbsl_pkg::LEVEL_RST : lnbsl_pkg::CONTROL_RST;
            end else if (commit && reg_idx_q == 8'(r)) begin
                regs_q[r] <= shift_q;
            end
        end
    end

    // open drain: only ever pulls low
    assign sda_o     = 1'b0;
    assign sda_oen_o = (state_q != lnbsl_pkg::ST_ACK);

    // ****************************************************************
    // output level selection
    // ****************************************************************
    wire        src_reg  = regs_q[lnbsl_pkg::REG_CONTROL][lnbsl_pkg::SRC_BIT];
    wire        reg_on   = regs_q[lnbsl_pkg::REG_CONTROL][lnbsl_pkg::REG_EN_BIT];
    wire [3:0]  reg_code = regs_q[lnbsl_pkg::REG_LEVEL][lnbsl_pkg::CODE_MSB:lnbsl_pkg::CODE_LSB];
    // clock line doubles as a select bit, so bus traffic moves the level in pin mode
    wire [3:0]  pin_code = vsel_s ? (scl_s ? lnbsl_pkg::CODE_19V4 : lnbsl_pkg::CODE_18V2)
                                  : (scl_s ? lnbsl_pkg::CODE_14V6 : lnbsl_pkg::CODE_13V4);
    lnbsl_pkg::lnbsl_supply_t supply_d;
    lnbsl_pkg::lnbsl_supply_t supply_q;

    assign supply_d = src_reg ? lnbsl_pkg::lnbsl_supply_t'{on: reg_on, level_code: reg_code} :
                      en_s    ? lnbsl_pkg::lnbsl_supply_t'{on: 1'b1,   level_code: pin_code} :
                                lnbsl_pkg::lnbsl_supply_t'{on: 1'b0,   level_code: lnbsl_pkg::CODE_OFF};

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            supply_q <= '{on: 1'b0, level_code: lnbsl_pkg::CODE_OFF};
        end else begin
            supply_q <= supply_d;
        end
    end

    assign dish_supply_output_o = supply_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_addr_done;
        byte_done && (byte_cnt_q == lnbsl_pkg::BYTE_ADDR);
    endsequence

    sequence s_ack_accepted;
        byte_done && ack_ok;
    endsequence

    a_pin_high_levels: assert property (!src_reg && en_s && vsel_s && !scl_s |=>
        supply_q.on && supply_q.level_code == lnbsl_pkg::CODE_18V2)
        else $error("pin mode 18.2 V level wrong");
    a_pin_low_levels: assert property (!src_reg && en_s && !vsel_s && scl_s |=>
        supply_q.on && supply_q.level_code == lnbsl_pkg::CODE_14V6)
        else $error("pin mode 14.6 V level wrong");
    a_pin_off_out: assert property (!src_reg && !en_s |=> !supply_q.on)
        else $error("output on with enable pin low");
    a_reg_level_follow: assert property (src_reg |=>
        supply_q.on == $past(reg_on) && supply_q.level_code == $past(reg_code))
        else $error("register mode output mismatch");
    a_ack_after_byte: assert property (s_ack_accepted |=> !sda_oen_o throughout (!scl_fall)[*2])
        else $error("acknowledge not held");
    a_nack_foreign_addr: assert property (s_addr_done ##0 !addr_hit |=> sda_oen_o [*2])
        else $error("foreign address acknowledged");
    a_commit_on_fall: assert property (commit && reg_idx_q == 8'(lnbsl_pkg::REG_CONTROL) |=>
        regs_q[lnbsl_pkg::REG_CONTROL] == $past(shift_q))
        else $error("data byte not committed");
    a_no_write_disabled: assert property (!en_s |=> $stable(regs_q))
        else $error("register changed with enable pin low");
    a_stop_to_idle: assert property (stop_det && !start_det |=> state_q == lnbsl_pkg::ST_IDLE)
        else $error("stop did not end frame");
endmodule
